// *** bwu_checker.sv ***
// Bus and debug event assertions for the breakpoint and watchpoint unit
`timescale 1ns/10ps
module bwu_checker
  import bwu_pkg::*;
(
  input wire logic        aclk,          // Core clock
  input wire logic        aresetn,       // Reset, low
  input wire logic        clk_en,        // Clock enable
  input wire logic        s_axi_awvalid, // Write address valid
  input wire logic        s_axi_awready, // Write address ready
  input wire logic        s_axi_wvalid,  // Write data valid
  input wire logic        s_axi_wready,  // Write data ready
  input wire logic [1:0]  s_axi_bresp,   // Write response
  input wire logic        s_axi_bvalid,  // Write response valid
  input wire logic        s_axi_bready,  // Write response ready
  input wire logic        s_axi_arvalid, // Read address valid
  input wire logic        s_axi_arready, // Read address ready
  input wire logic [31:0] s_axi_rdata,   // Read data
  input wire logic        s_axi_rvalid,  // Read data valid
  input wire logic        s_axi_rready,  // Read data ready
  input wire bwu_fetch_s  fetch,         // Fetch
  input wire bwu_mem_s    mem_op,        // Memory operation
  input wire bwu_res_s    res_op,        // Resource operation
  input wire logic        dbg_irq,       // Debug interrupt
  input wire logic [17:0] dbg_type,      // Cause record
  input wire logic [31:0] dbg_data       // Address or id
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !clk_en);
  // ==========================
  // Register bus
  property p_w_ans; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid;
  endproperty
  a_w_ans: assert property (p_w_ans) else $error("no write response");
  property p_r_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_r_ans: assert property (p_r_ans) else $error("no read response");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_busy: assert property (p_busy) else $error("write taken while busy");
  // ==========================
  // Debug events
  property p_ib; dbg_irq && dbg_type[2:0] == 3'h3 |-> $past(fetch.valid)
    && dbg_type[15:8] == {5'h00, $past(fetch.thread)}; endproperty
  a_ib: assert property (p_ib) else $error("breakpoint record wrong");
  property p_dw; dbg_irq && dbg_type[2:0] == 3'h4 |-> $past(mem_op.valid)
    && dbg_data == $past(mem_op.addr); endproperty
  a_dw: assert property (p_dw) else $error("data watch record wrong");
  property p_rw; dbg_irq && dbg_type[2:0] == 3'h5 |-> $past(res_op.valid)
    && dbg_data == $past(res_op.res_id); endproperty
  a_rw: assert property (p_rw) else $error("resource watch record wrong");
  property p_cause; dbg_irq |-> dbg_type[2:0] inside {3'h3, 3'h4, 3'h5}; endproperty
  a_cause: assert property (p_cause) else $error("bad cause code");
  c_wr: cover property (s_axi_bvalid && s_axi_bready);
  c_rd: cover property (s_axi_rvalid && s_axi_rready);
  c_irq: cover property (dbg_irq);
endmodule : bwu_checker

bind bwu_top bwu_checker chk_u (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .fetch(fetch), .mem_op(mem_op), .res_op(res_op), .dbg_irq(dbg_irq), .dbg_type(dbg_type),
  .dbg_data(dbg_data));

// *** bwu_params.svh ***
// Register map, field positions and reset values of the breakpoint and watchpoint unit
`ifndef BWU_PARAMS_SVH
`define BWU_PARAMS_SVH
`define BWU_IDX_IBRK_ADDR   8'h30
`define BWU_IDX_IBRK_CTRL   8'h40
`define BWU_IDX_DW_ADDR1    8'h50
`define BWU_IDX_DW_ADDR2    8'h60
`define BWU_IDX_DW_CTRL     8'h70
`define BWU_IDX_RW_MASK     8'h80
`define BWU_IDX_RW_VALUE    8'h90
`define BWU_IDX_RW_CTRL     8'h9C
`define BWU_IDX_DBG_TYPE    8'h15
`define BWU_IDX_DBG_DATA    8'h16
`define BWU_BIT_EN          0
`define BWU_BIT_MODE        1
`define BWU_BIT_LOADS       2
`define BWU_THR_LSB         16
`define BWU_THR_MSB         23
`define BWU_IB_CTRL_MASK    32'h00FF0003
`define BWU_DW_CTRL_MASK    32'h00FF0007
`define BWU_RW_CTRL_MASK    32'h00FF0003
`define BWU_CTRL_RST        32'h00000000
`define BWU_DBG_TYPE_MASK   18'h3FF07
`define BWU_CAUSE_IBRK      3'h3
`define BWU_CAUSE_DWATCH    3'h4
`define BWU_CAUSE_RWATCH    3'h5
`define BWU_RESP_OKAY       2'h0
`define BWU_RESP_SLVERR     2'h2
`endif

// *** bwu_pipe_model.sv ***
// Processor pipeline model issuing fetches, memory and resource operations
`timescale 1ns/10ps
module bwu_pipe_model
  import bwu_pkg::*;
(
  input wire logic aclk,   // Core clock
  output bwu_fetch_s fetch,  // Fetch
  output bwu_mem_s   mem_op, // Memory operation
  output bwu_res_s   res_op  // Resource operation
);
  initial begin
    fetch = '0;
    mem_op = '0;
    res_op = '0;
  end
  // One-cycle issue; payload inverted afterwards so stale values never match
  task issue(input logic [1:0] k, input logic ld, input logic [2:0] th, input logic [31:0] v);
    @(posedge aclk);
    case (k)
      2'd0: fetch <= '{1'b1, th, v};
      2'd1: mem_op <= '{1'b1, ld, th, v};
      default: res_op <= '{1'b1, th, v};
    endcase
    @(posedge aclk);
    fetch <= '{1'b0, ~th, ~v};
    mem_op <= '{1'b0, ~ld, ~th, ~v};
    res_op <= '{1'b0, ~th, ~v};
  endtask : issue
endmodule : bwu_pipe_model

// *** bwu_pkg.sv ***
// Types shared by the breakpoint and watchpoint unit
package bwu_pkg;
  typedef enum logic [2:0] {
    BWU_RD_IDLE = 3'b001,
    BWU_RD_RESP = 3'b010,
    BWU_RD_HOLD = 3'b100
  } bwu_rd_e;

  typedef struct packed {
    logic        valid;
    logic [2:0]  thread;
    logic [31:0] pc;
  } bwu_fetch_s;

  typedef struct packed {
    logic        valid;
    logic        is_load;
    logic [2:0]  thread;
    logic [31:0] addr;
  } bwu_mem_s;

  typedef struct packed {
    logic        valid;
    logic [2:0]  thread;
    logic [31:0] res_id;
  } bwu_res_s;

  typedef struct packed {
    logic [3:0][31:0] ib_addr;
    logic [3:0][31:0] ib_ctrl;
    logic [3:0][31:0] dw_addr1;
    logic [3:0][31:0] dw_addr2;
    logic [3:0][31:0] dw_ctrl;
    logic [3:0][31:0] rw_mask;
    logic [3:0][31:0] rw_value;
    logic [3:0][31:0] rw_ctrl;
    logic [17:0]      dbg_type;
    logic [31:0]      dbg_data;
    logic             aw_got;
    logic [7:0]       aw_idx;
    logic             w_got;
    logic [31:0]      w_data;
    logic             bvalid;
    logic [1:0]       bresp;
    bwu_rd_e          rd_state;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
    logic             dbg_irq;
  } bwu_state_s;
endpackage : bwu_pkg

// *** bwu_top.sv ***
// Breakpoint and watchpoint comparators with an AXI4-Lite register bank
//
// Function
// (RL1) Four instruction breakpoint control registers at 0x40
// (RL2) Per-thread enable field gates breakpoint matches
// (RL3) Breakpoint bit 0 globally enables it
// (RL4) Bit 1 chooses equal or unequal PC
// (RL5) Four data watch first address registers
// (RL6) Four data watch second address registers
// (RL7) Data watch control: enable, thread field
// (RL8) Data watch bit 2 adds loads
// (RL9) Data watch bit 1: AND or OR
// (RL10) Four resource watch mask registers
// (RL11) Four resource watch compare value registers
// (RL12) Resource watch bit 1 selects condition B
// (RL13) Watch controls have thread field, enable
// (RL14) Data A: addr>=first; B: addr<=second
// (RL15) Resource A: masked equal; B: differ
// (RL16) Four breakpoint address registers compared with PC
// (RL17) Record cause code 3/4/5 and thread
// (RL18) Lowest triggering unit number is recorded
// (RL19) Store address or resource ID
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/10ps
`include "bwu_params.svh"
module bwu_top
  import bwu_pkg::*;
(
  input  wire logic        aclk,           // Core clock
  input  wire logic        aresetn,        // Synchronous reset, low
  input  wire logic        clk_en,         // Freezes all state when low unless aresetn is low
  input  wire logic [31:0] s_axi_awaddr,   // Write address
  input  wire logic        s_axi_awvalid,  // Write address valid
  output      logic        s_axi_awready,  // Write address ready
  input  wire logic [31:0] s_axi_wdata,    // Write data
  input  wire logic [3:0]  s_axi_wstrb,    // Write byte enables
  input  wire logic        s_axi_wvalid,   // Write data valid
  output      logic        s_axi_wready,   // Write data ready
  output      logic [1:0]  s_axi_bresp,    // Write response
  output      logic        s_axi_bvalid,   // Write response valid
  input  wire logic        s_axi_bready,   // Write response ready
  input  wire logic [31:0] s_axi_araddr,   // Read address
  input  wire logic        s_axi_arvalid,  // Read address valid
  output      logic        s_axi_arready,  // Read address ready
  output      logic [31:0] s_axi_rdata,    // Read data
  output      logic [1:0]  s_axi_rresp,    // Read response
  output      logic        s_axi_rvalid,   // Read data valid
  input  wire logic        s_axi_rready,   // Read data ready
  input  wire bwu_fetch_s  fetch,          // Issued instruction PC
  input  wire bwu_mem_s    mem_op,         // Memory operation address
  input  wire bwu_res_s    res_op,         // Resource operation identifier
  output      logic        dbg_irq,        // Debug interrupt pulse
  output      logic [17:0] dbg_type,       // Unit, thread, cause
  output      logic [31:0] dbg_data        // Address or resource ID
);

  bwu_state_s st_reg;
  bwu_state_s st_next;

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] apply_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction : apply_strb

  // Global enable and thread bit both required
  function automatic logic armed(input logic [31:0] ctrl, input logic [2:0] thr);
    logic [7:0] thr_en;
    thr_en = ctrl[`BWU_THR_MSB:`BWU_THR_LSB];
    return ctrl[`BWU_BIT_EN] && thr_en[thr];
  endfunction : armed

  // Tests whether an index lies in a group's four slots; hit means group matched
  function automatic logic in_group(input logic [7:0] idx, input logic [7:0] base);
    return (idx >= base) && (idx < base + 8'h04);
  endfunction : in_group

  // ==========================================================================
  // Comparators
  logic [3:0] ib_hit;
  logic [3:0] dw_hit;
  logic [3:0] rw_hit;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      logic pc_eq;
      logic cond_a;
      logic cond_b;
      logic dw_ok;
      logic res_eq;
      pc_eq  = 1'b0;
      cond_a = 1'b0;
      cond_b = 1'b0;
      dw_ok  = 1'b0;
      res_eq = 1'b0;
      // (RL16) PC against breakpoint address
      pc_eq = (fetch.pc == st_reg.ib_addr[i]);
      // (RL2) (RL3) (RL4) Gated equal or unequal match
      ib_hit[i] = fetch.valid && armed(st_reg.ib_ctrl[i], fetch.thread) &&
                  (st_reg.ib_ctrl[i][`BWU_BIT_MODE] ? !pc_eq : pc_eq);
      // (RL14) Lower and upper address bounds
      cond_a = (mem_op.addr >= st_reg.dw_addr1[i]);
      cond_b = (mem_op.addr <= st_reg.dw_addr2[i]);
      // (RL9) AND or OR combination
      dw_ok = st_reg.dw_ctrl[i][`BWU_BIT_MODE] ? (cond_a || cond_b) : (cond_a && cond_b);
      // (RL7) (RL8) (RL13) Loads only when bit 2 set
      dw_hit[i] = mem_op.valid && armed(st_reg.dw_ctrl[i], mem_op.thread) && dw_ok &&
                  (!mem_op.is_load || st_reg.dw_ctrl[i][`BWU_BIT_LOADS]);
      // (RL15) Masked compare, equal or differing
      res_eq = ((res_op.res_id & st_reg.rw_mask[i]) ==
                (st_reg.rw_value[i] & st_reg.rw_mask[i]));
      // (RL12) (RL13) Condition A or B selection
      rw_hit[i] = res_op.valid && armed(st_reg.rw_ctrl[i], res_op.thread) &&
                  (st_reg.rw_ctrl[i][`BWU_BIT_MODE] ? !res_eq : res_eq);
    end
  end

  function automatic logic [1:0] lowest(input logic [3:0] v);
    logic [1:0] n;
    n = 2'h0;
    for (int k = 3; k >= 0; k--) begin
      if (v[k]) begin
        n = k[1:0];
      end
    end
    return n;
  endfunction : lowest

  // ==========================================================================
  // Capture selection
  logic        cap_fire;
  logic        cap_has_data;
  logic [2:0]  cap_cause;
  logic [2:0]  cap_thread;
  logic [1:0]  cap_unit;
  logic [31:0] cap_data;

  // One capture per cycle; lower classes are dropped, not queued
  // (RL17) (RL18) Priority: breakpoint, data, resource
  always_comb begin
    cap_fire     = 1'b0;
    cap_has_data = 1'b0;
    cap_cause    = `BWU_CAUSE_IBRK;
    cap_thread   = 3'h0;
    cap_unit     = 2'h0;
    cap_data     = 32'h00000000;
    if (|ib_hit) begin
      cap_fire   = 1'b1;
      cap_thread = fetch.thread;
      cap_unit   = lowest(ib_hit);
    end else if (|dw_hit) begin
      cap_fire     = 1'b1;
      cap_has_data = 1'b1;
      cap_cause    = `BWU_CAUSE_DWATCH;
      cap_thread   = mem_op.thread;
      cap_unit     = lowest(dw_hit);
      cap_data     = mem_op.addr;
    end else if (|rw_hit) begin
      cap_fire     = 1'b1;
      cap_has_data = 1'b1;
      cap_cause    = `BWU_CAUSE_RWATCH;
      cap_thread   = res_op.thread;
      cap_unit     = lowest(rw_hit);
      cap_data     = res_op.res_id;
    end
  end

  // ==========================================================================
  // Register read mux
  function automatic logic [32:0] rd_word(input bwu_state_s s, input logic [7:0] idx);
    logic [32:0] r;
    logic [1:0]  sl;
    sl = idx[1:0];
    r  = {1'b0, 32'h00000000};
    if (in_group(idx, `BWU_IDX_IBRK_ADDR)) begin
      r = {1'b1, s.ib_addr[sl]};
    end else if (in_group(idx, `BWU_IDX_IBRK_CTRL)) begin
      r = {1'b1, s.ib_ctrl[sl]};
    end else if (in_group(idx, `BWU_IDX_DW_ADDR1)) begin
      r = {1'b1, s.dw_addr1[sl]};
    end else if (in_group(idx, `BWU_IDX_DW_ADDR2)) begin
      r = {1'b1, s.dw_addr2[sl]};
    end else if (in_group(idx, `BWU_IDX_DW_CTRL)) begin
      r = {1'b1, s.dw_ctrl[sl]};
    end else if (in_group(idx, `BWU_IDX_RW_MASK)) begin
      r = {1'b1, s.rw_mask[sl]};
    end else if (in_group(idx, `BWU_IDX_RW_VALUE)) begin
      r = {1'b1, s.rw_value[sl]};
    end else if (in_group(idx, `BWU_IDX_RW_CTRL)) begin
      r = {1'b1, s.rw_ctrl[sl]};
    end else if (idx == `BWU_IDX_DBG_TYPE) begin
      r = {1'b1, 14'h0000, s.dbg_type};
    end else if (idx == `BWU_IDX_DBG_DATA) begin
      r = {1'b1, s.dbg_data};
    end
    return r;
  endfunction : rd_word

  // ==========================================================================
  // Next state
  logic        wr_fire;
  logic [32:0] rd_res;

  assign s_axi_awready = !st_reg.aw_got && !st_reg.bvalid;
  assign s_axi_wready  = !st_reg.w_got && !st_reg.bvalid;
  assign s_axi_arready = (st_reg.rd_state == BWU_RD_IDLE);
  assign wr_fire       = st_reg.aw_got && st_reg.w_got && !st_reg.bvalid;

  always_comb begin
    logic [7:0]  widx;
    logic [1:0]  wsl;
    logic [31:0] wv;
    logic        wok;
    widx    = st_reg.aw_idx;
    wsl     = widx[1:0];
    wv      = 32'h00000000;
    wok     = 1'b1;
    rd_res  = rd_word(st_reg, s_axi_araddr[9:2]);
    st_next = st_reg;
    st_next.dbg_irq = 1'b0;

    if (s_axi_awvalid && s_axi_awready) begin
      st_next.aw_got = 1'b1;
      st_next.aw_idx = s_axi_awaddr[9:2];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_next.w_got  = 1'b1;
      st_next.w_data = apply_strb(32'h00000000, s_axi_wdata, s_axi_wstrb);
    end

    if (wr_fire) begin
      wv = st_reg.w_data;
      if (in_group(widx, `BWU_IDX_IBRK_ADDR)) begin
        st_next.ib_addr[wsl] = wv;
      end else if (in_group(widx, `BWU_IDX_IBRK_CTRL)) begin
        // (RL1) Reserved bits stay zero
        st_next.ib_ctrl[wsl] = wv & `BWU_IB_CTRL_MASK;
      end else if (in_group(widx, `BWU_IDX_DW_ADDR1)) begin
        // (RL5) First address store
        st_next.dw_addr1[wsl] = wv;
      end else if (in_group(widx, `BWU_IDX_DW_ADDR2)) begin
        // (RL6) Second address store
        st_next.dw_addr2[wsl] = wv;
      end else if (in_group(widx, `BWU_IDX_DW_CTRL)) begin
        st_next.dw_ctrl[wsl] = wv & `BWU_DW_CTRL_MASK;
      end else if (in_group(widx, `BWU_IDX_RW_MASK)) begin
        // (RL10) Mask store
        st_next.rw_mask[wsl] = wv;
      end else if (in_group(widx, `BWU_IDX_RW_VALUE)) begin
        // (RL11) Compare value store
        st_next.rw_value[wsl] = wv;
      end else if (in_group(widx, `BWU_IDX_RW_CTRL)) begin
        st_next.rw_ctrl[wsl] = wv & `BWU_RW_CTRL_MASK;
      end else if (widx == `BWU_IDX_DBG_TYPE) begin
        st_next.dbg_type = wv[17:0] & `BWU_DBG_TYPE_MASK;
      end else if (widx == `BWU_IDX_DBG_DATA) begin
        st_next.dbg_data = wv;
      end else begin
        wok = 1'b0;
      end
      st_next.aw_got = 1'b0;
      st_next.w_got  = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp  = wok ? `BWU_RESP_OKAY : `BWU_RESP_SLVERR;
    end else if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end

    case (st_reg.rd_state)
      BWU_RD_IDLE: begin
        if (s_axi_arvalid) begin
          st_next.rdata    = rd_res[31:0];
          st_next.rresp    = rd_res[32] ? `BWU_RESP_OKAY : `BWU_RESP_SLVERR;
          st_next.rd_state = BWU_RD_RESP;
        end
      end
      BWU_RD_RESP: begin
        if (s_axi_rready) begin
          st_next.rd_state = BWU_RD_IDLE;
        end else begin
          st_next.rd_state = BWU_RD_HOLD;
        end
      end
      BWU_RD_HOLD: begin
        if (s_axi_rready) begin
          st_next.rd_state = BWU_RD_IDLE;
        end
      end
      default: begin
        st_next.rd_state = BWU_RD_IDLE;
      end
    endcase

    // Hardware capture overrides a same-cycle software write to dbg_type, and to dbg_data only on data or resource watch captures
    if (cap_fire) begin
      st_next.dbg_irq  = 1'b1;
      st_next.dbg_type = {cap_unit, 5'h00, cap_thread, 5'h00, cap_cause};
      // (RL19) Address or resource ID for the debugger
      if (cap_has_data) begin
        st_next.dbg_data = cap_data;
      end
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg          <= '0;
      st_reg.ib_ctrl  <= {4{`BWU_CTRL_RST}};
      st_reg.dw_ctrl  <= {4{`BWU_CTRL_RST}};
      st_reg.rw_ctrl  <= {4{`BWU_CTRL_RST}};
      st_reg.rd_state <= BWU_RD_IDLE;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp  = st_reg.bresp;
  assign s_axi_rvalid = (st_reg.rd_state != BWU_RD_IDLE);
  assign s_axi_rdata  = st_reg.rdata;
  assign s_axi_rresp  = st_reg.rresp;
  assign dbg_irq      = st_reg.dbg_irq;
  assign dbg_type     = st_reg.dbg_type;
  assign dbg_data     = st_reg.dbg_data;

endmodule : bwu_top

// *** tb_breakpoint_watchpoint_unit.sv ***
// Register and trigger tests of the breakpoint and watchpoint unit
`timescale 1ns/10ps
`include "bwu_params.svh"
module tb_breakpoint_watchpoint_unit
  import bwu_pkg::*;
;
  logic aclk, aresetn, clk_en, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, dbg_irq;
  logic [31:0] awaddr, wdata, araddr, rdata, dbg_data, d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  logic [17:0] dbg_type;
  bwu_fetch_s fetch;
  bwu_mem_s   mem_op;
  bwu_res_s   res_op;
  int mismatches, compares, cyc;
  logic [7:0] cb[3] = '{`BWU_IDX_IBRK_CTRL, `BWU_IDX_DW_CTRL, `BWU_IDX_RW_CTRL};
  logic [31:0] cm[3] = '{`BWU_IB_CTRL_MASK, `BWU_DW_CTRL_MASK, `BWU_RW_CTRL_MASK};
  logic [7:0] db[5] = '{`BWU_IDX_IBRK_ADDR, `BWU_IDX_DW_ADDR1, `BWU_IDX_DW_ADDR2,
                        `BWU_IDX_RW_MASK, `BWU_IDX_RW_VALUE};
  bwu_top dut_u (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .fetch(fetch), .mem_op(mem_op), .res_op(res_op),
    .dbg_irq(dbg_irq), .dbg_type(dbg_type), .dbg_data(dbg_data));
  bwu_pipe_model pipe_u (.aclk(aclk), .fetch(fetch), .mem_op(mem_op), .res_op(res_op));
  initial begin
    aclk = 0;
    forever #20 aclk = ~aclk;
  end
  function automatic logic [31:0] a(input logic [7:0] b, input int u);
    return {22'h0, b + 8'(u), 2'b00};
  endfunction : a
  task finish_test;
    if (mismatches == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task wr(input logic [31:0] ad, input logic [31:0] dt);
    logic ad_done, dt_done;
    @(posedge aclk);
    awaddr <= ad; wdata <= dt; awvalid <= 1; wvalid <= 1; bready <= 1;
    ad_done = 0;
    dt_done = 0;
    while (!(ad_done && dt_done)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        ad_done = 1;
        awvalid <= 0;
      end
      if (wvalid && wready) begin
        dt_done = 1;
        wvalid <= 0;
      end
    end
    while (!bvalid) @(posedge aclk);
    r = bresp;
    bready <= 0;
  endtask : wr
  task rd(input logic [31:0] ad);
    @(posedge aclk);
    araddr <= ad; arvalid <= 1; rready <= 1;
    do @(posedge aclk); while (!arready);
    arvalid <= 0;
    do @(posedge aclk); while (!rvalid);
    d = rdata; r = rresp;
    rready <= 0;
  endtask : rd
  // Issue one operation, then look at the pulse one cycle later
  task ev(input logic [1:0] k, input logic ld, input logic [2:0] th, input logic [31:0] v,
          input logic ei, input logic [1:0] u);
    pipe_u.issue(k, ld, th, v);
    @(negedge aclk);
    chk(32'(dbg_irq), 32'(ei));
    if (ei) chk(32'(dbg_type), 32'({u, 5'h00, th, 5'h00, 3'(k + 3)}));
    if (ei && k != 0) chk(dbg_data, v);
  endtask : ev
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      finish_test;
    end
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, mismatches, compares, cyc} = '0;
    clk_en = 1; awaddr = 0; wdata = 0; araddr = 0; wstrb = 4'hF;
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    for (int j = 0; j < 3; j++) for (int u = 0; u < 4; u++) begin
      rd(a(cb[j], u)); chk(d, `BWU_CTRL_RST);
      wr(a(cb[j], u), 32'hFFFFFFFF); rd(a(cb[j], u)); chk(d, cm[j]);
      wr(a(cb[j], u), 32'h0);
    end
    for (int j = 0; j < 5; j++) for (int u = 0; u < 4; u++) begin
      wr(a(db[j], u), 32'hA5C30F00 + 32'(j * 4 + u));
      chk(32'(r), 32'(`BWU_RESP_OKAY));
      rd(a(db[j], u)); chk(d, 32'hA5C30F00 + 32'(j * 4 + u));
      chk(32'(r), 32'(`BWU_RESP_OKAY));
    end
    rd(32'h3FC); chk(d, 0); chk(32'(r), 32'(`BWU_RESP_SLVERR));
    wr(32'h3FC, 32'h1); chk(32'(r), 32'(`BWU_RESP_SLVERR));
    wr(a(`BWU_IDX_DBG_TYPE, 0), 32'hFFFFFFFF);
    rd(a(`BWU_IDX_DBG_TYPE, 0)); chk(d, 32'h0003FF07);
    wr(a(`BWU_IDX_IBRK_ADDR, 1), 32'h1000); wr(a(`BWU_IDX_IBRK_CTRL, 1), 32'h00040001);
    ev(0, 0, 2, 32'h1000, 1, 1);
    ev(0, 0, 3, 32'h1000, 0, 1);
    ev(0, 0, 2, 32'h1004, 0, 1);
    wr(a(`BWU_IDX_IBRK_CTRL, 1), 32'h00040003);
    ev(0, 0, 2, 32'h1004, 1, 1);
    ev(0, 0, 2, 32'h1000, 0, 1);
    wr(a(`BWU_IDX_IBRK_CTRL, 1), 32'h00040002);
    ev(0, 0, 2, 32'h1004, 0, 1);
    for (int u = 2; u < 4; u++) begin
      wr(a(`BWU_IDX_IBRK_ADDR, u), 32'h2000); wr(a(`BWU_IDX_IBRK_CTRL, u), 32'h00010001);
    end
    clk_en <= 0;
    ev(0, 0, 0, 32'h2000, 0, 2);
    clk_en <= 1;
    ev(0, 0, 0, 32'h2000, 1, 2);
    wr(a(`BWU_IDX_DW_ADDR1, 0), 32'h100); wr(a(`BWU_IDX_DW_ADDR2, 0), 32'h1FF);
    wr(a(`BWU_IDX_DW_CTRL, 0), 32'h00010001);
    ev(1, 0, 0, 32'h180, 1, 0);
    ev(1, 0, 0, 32'h200, 0, 0);
    ev(1, 1, 0, 32'h180, 0, 0);
    wr(a(`BWU_IDX_DW_CTRL, 0), 32'h00010007);
    ev(1, 0, 0, 32'h200, 1, 0);
    ev(1, 1, 0, 32'h0F0, 1, 0);
    wr(a(`BWU_IDX_RW_MASK, 0), 32'hFF); wr(a(`BWU_IDX_RW_VALUE, 0), 32'h12);
    wr(a(`BWU_IDX_RW_CTRL, 0), 32'h00010001);
    ev(2, 0, 0, 32'hAB12, 1, 0);
    ev(2, 0, 0, 32'hAB13, 0, 0);
    wr(a(`BWU_IDX_RW_CTRL, 0), 32'h00010003);
    ev(2, 0, 0, 32'hAB13, 1, 0);
    ev(2, 0, 0, 32'h0012, 0, 0);
    wr(a(`BWU_IDX_RW_CTRL, 0), 32'h00010002);
    ev(2, 0, 0, 32'hAB13, 0, 0);
    finish_test;
  end
endmodule : tb_breakpoint_watchpoint_unit
